// >>> verilog/serial_port_pkg.sv
// Purpose: shared constants, types and helpers of the block serial port
// Assumes: classic Wishbone slave with byte-wide registers in the low lane
// Notes: command bits are named by position inside each command byte
`default_nettype none

package serial_port_pkg;

  // register word offsets (byte addresses)
  localparam logic [7:0] ADDR_DATA = 8'h00; // fifo data
  localparam logic [7:0] ADDR_CMD1 = 8'h04; // write: command 1, read: status 1
  localparam logic [7:0] ADDR_CMD2 = 8'h08; // bit-rate divider setting n
  localparam logic [7:0] ADDR_CMD3 = 8'h0c; // block length setting m
  localparam logic [7:0] ADDR_CMD4 = 8'h10; // enables, wakeup, rts, fault clear
  localparam logic [7:0] ADDR_CMD5 = 8'h14; // own station address
  localparam logic [7:0] ADDR_CMD6 = 8'h18; // ports and interrupt polarity

  // command 1 fields
  localparam int C1_PRESCALE = 0; // 1: divide by 32, 0: divide by 2
  localparam int C1_PAR_EN = 1; // parity bit present
  localparam int C1_PAR_ODD = 2; // odd parity when set
  localparam int C1_CRC_EN = 3; // two check bytes per block
  localparam int C1_TWO_STOP = 4; // two stop bits when set
  // command 4 fields
  localparam int C4_TRANSMIT_ENABLE_BIT = 0; // transmit_enable_bit
  localparam int C4_RECEIVE_ENABLE_BIT = 1; // receive_enable_bit
  localparam int C4_WAKE = 2; // wakeup mode
  localparam int C4_RTS = 3; // request-to-send level
  localparam int C4_CLR = 4; // fault_clear_bit
  // command 6 fields
  localparam int C6_P0 = 0; // port_out_zero level
  localparam int C6_P1_MODE = 1; // 1: port one shows packet done
  localparam int C6_INT_HIGH = 2; // 1: interrupt active high, 0: active low
  localparam int C6_P1_LEVEL = 3; // port one level in general mode
  // status 1 fields
  localparam int S_PE = 0; // packet_end_flag
  localparam int S_BF = 1; // buffer_full_flag
  localparam int S_TXE = 2; // transmit fifo empty
  localparam int S_FE = 3; // framing error
  localparam int S_OVR = 4; // overrun
  localparam int S_PAR = 5; // parity error
  localparam int S_CRC = 6; // crc error
  localparam int S_TXBUSY = 7; // transmitter working

  localparam logic [7:0] CMD_RESET = 8'h00; // every command after reset

  // rate generation
  localparam int PRESCALE_FAST = 2;
  localparam int PRESCALE_SLOW = 32;
  localparam logic [4:0] PRE_FAST_LAST = 5'(PRESCALE_FAST - 1);
  localparam logic [4:0] PRE_SLOW_LAST = 5'(PRESCALE_SLOW - 1);
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] TICK_MID = 4'(OVERSAMPLE / 2 - 1);

  // fifo and frame
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [1:0] CRC_BYTES = 2'h2;

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

  typedef struct packed {
    logic [3:0] len; // bits in frame, start and stops included
    logic [11:0] bits; // sent lsb first
  } frame_t;

  typedef struct packed {
    logic [7:0] data;
    logic wake;
    logic parErr;
    logic frameErr;
  } rx_char_t;

  // one byte of crc, msb first, no final inversion
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ data[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // parity over data and wake bit
  function automatic logic par_bit(input logic [7:0] data, input logic wake, input logic odd);
    return ^data ^ wake ^ odd;
  endfunction

  // builds one outgoing character, unused high bits stay at mark
  function automatic frame_t build_frame(input logic [7:0] data, input logic wakeOn,
      input logic wakeBit, input logic parOn, input logic parOdd, input logic twoStop);
    frame_t f;
    int p;
    f.bits = 12'hfff;
    f.bits[0] = 1'b0;
    f.bits[8:1] = data;
    p = 9;
    if (wakeOn) begin
      f.bits[p] = wakeBit;
      p++;
    end
    if (parOn) begin
      f.bits[p] = par_bit(data, wakeOn & wakeBit, parOdd);
      p++;
    end
    f.len = 4'(p + 1 + int'(twoStop));
    return f;
  endfunction

  // splits received bits (start excluded) into fields
  function automatic rx_char_t decode_frame(input logic [10:0] bits, input logic wakeOn,
      input logic parOn, input logic parOdd);
    rx_char_t r;
    int p;
    r.data = bits[7:0];
    p = 8;
    r.wake = 1'b0;
    if (wakeOn) begin
      r.wake = bits[p];
      p++;
    end
    r.parErr = 1'b0;
    if (parOn) begin
      r.parErr = bits[p] != par_bit(bits[7:0], r.wake, parOdd);
      p++;
    end
    r.frameErr = ~bits[p];
    return r;
  endfunction

endpackage

`default_nettype wire

// >>> verilog/block_fifo_async_serial_port.sv
// Purpose: block-oriented asynchronous serial port with 4-byte fifos
// Assumes: 25 MHz clock, classic Wishbone register access, async low reset
// Notes: offset 0x00 is the fifo data port, 0x04 is command/status
`timescale 1ns/1ps
`default_nettype none

module block_fifo_async_serial_port (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic serialIn,
  output logic serialOut,
  input wire logic ctsN,
  output logic rtsOut,
  output logic intOut,
  output logic portOutZero,
  output logic portOutOnePacketDone
);

  // command registers, all cleared by reset
  logic [7:0] cmd1_q, cmd2_q, cmd3_q, cmd4_q, cmd5_q, cmd6_q;
  logic ack_q; // bus answer
  logic [7:0] rdData_q; // registered read byte
  // pin synchronisers, three stages each
  logic [2:0] rxSync_q, ctsSync_q;
  logic rxLine_q, ctsLine_q; // filtered pin levels
  // rate generator
  logic [4:0] preCnt_q;
  logic [7:0] divCnt_q;
  // transmit side
  logic [7:0] txMem [4]; // transmit fifo storage
  logic [1:0] txWr_q, txRd_q;
  logic [2:0] txCount_q;
  logic [5:0] txWrIdx_q; // byte of block being written
  logic txGroupDone_q; // group complete, waiting to go
  logic txRelease_q; // fifo draining into shifter
  logic [5:0] txIdx_q; // byte of block being sent
  logic [15:0] txCrc_q;
  logic [1:0] txCrcLeft_q; // check bytes still to send
  logic txLast_q; // frame in flight closes a block
  logic txDone_q; // packet transmission complete
  serial_port_pkg::tx_state_t txState_q;
  logic [11:0] txFrame_q;
  logic [3:0] txLeft_q, txPhase_q;
  logic serialOut_q;
  // receive side
  logic [7:0] rxMem [4]; // receive fifo storage
  logic [1:0] rxWr_q, rxRd_q;
  logic [2:0] rxCount_q;
  serial_port_pkg::rx_state_t rxState_q;
  logic [3:0] rxPhase_q, rxPos_q;
  logic [10:0] rxBits_q;
  logic rxDone_q; // one full character captured
  logic [5:0] rxIdx_q;
  logic [15:0] rxCrc_q;
  logic [1:0] rxCrcLeft_q;
  logic rxAwake_q; // addressed in wakeup mode
  logic peFlag_q, bfFlag_q, feFlag_q, ovrFlag_q, parFlag_q, crcFlag_q;
  logic intOut_q;

  // bus decode
  wire busReq = cyc_i & stb_i & ~ack_q; // one answer per request
  wire wrEn = busReq & we_i & sel_i[0];
  wire rdEn = busReq & ~we_i;
  wire hitData = adr_i == serial_port_pkg::ADDR_DATA; // data side of the port
  wire hitCmd1 = adr_i == serial_port_pkg::ADDR_CMD1; // command/status side
  wire hitCmd2 = adr_i == serial_port_pkg::ADDR_CMD2;
  wire hitCmd3 = adr_i == serial_port_pkg::ADDR_CMD3;
  wire hitCmd4 = adr_i == serial_port_pkg::ADDR_CMD4;
  wire hitCmd5 = adr_i == serial_port_pkg::ADDR_CMD5;
  wire hitCmd6 = adr_i == serial_port_pkg::ADDR_CMD6;

  // command fields
  wire parOn = cmd1_q[serial_port_pkg::C1_PAR_EN];
  wire parOdd = cmd1_q[serial_port_pkg::C1_PAR_ODD];
  wire crcOn = cmd1_q[serial_port_pkg::C1_CRC_EN] & ~parOn; // parity has priority
  wire twoStop = cmd1_q[serial_port_pkg::C1_TWO_STOP];
  wire [5:0] blockLast = cmd3_q[5:0]; // block is m+1 bytes
  wire txEnable = cmd4_q[serial_port_pkg::C4_TRANSMIT_ENABLE_BIT];
  wire rxEnable = cmd4_q[serial_port_pkg::C4_RECEIVE_ENABLE_BIT];
  wire wakeOn = cmd4_q[serial_port_pkg::C4_WAKE];
  wire faultClear = wrEn & hitCmd4 & dat_i[serial_port_pkg::C4_CLR];

  // rate: prescaler then n+1 divider, one pulse per sixteenth of a bit
  wire [4:0] preLast = cmd1_q[serial_port_pkg::C1_PRESCALE] ?
      serial_port_pkg::PRE_SLOW_LAST : serial_port_pkg::PRE_FAST_LAST;
  wire preTick = preCnt_q == preLast;
  wire tick16 = preTick & (divCnt_q == cmd2_q); // divide by n+1

  // transmit fifo decode
  wire txFull = txCount_q == serial_port_pkg::FIFO_DEPTH;
  wire txEmpty = txCount_q == 3'h0;
  // writes refused while a group waits or drains or the fifo is full; a group fills from empty
  wire txPush = wrEn & hitData & ~txRelease_q & ~txGroupDone_q & ~txFull;
  wire txBlockEndW = txWrIdx_q == blockLast;
  wire txGo = txGroupDone_q & txEnable & ~ctsLine_q; // start gate
  wire txIdle = txState_q == serial_port_pkg::TX_IDLE;
  wire txStartCrc = txIdle & (txCrcLeft_q != 2'h0);
  // once released the fifo drains whatever clear-to-send does
  wire txStartData = txIdle & ~txStartCrc & txRelease_q & ~txEmpty;
  wire txPop = txStartData;
  wire txBlockEndS = txIdx_q == blockLast;
  wire txFirst = txIdx_q == 6'h00; // ninth bit set only here
  wire [7:0] txByte = txStartCrc ?
      ((txCrcLeft_q == serial_port_pkg::CRC_BYTES) ? txCrc_q[15:8] : txCrc_q[7:0]) :
      txMem[txRd_q];
  wire [15:0] txCrcNext = serial_port_pkg::crc_step(txFirst ? serial_port_pkg::CRC_INIT :
      txCrc_q, txByte);
  wire serial_port_pkg::frame_t txNew = serial_port_pkg::build_frame(txByte, wakeOn,
      txStartData & txFirst, parOn, parOdd, twoStop);
  wire txBitEnd = (txState_q == serial_port_pkg::TX_SEND) & tick16 &
      (txPhase_q == serial_port_pkg::TICK_LAST);

  // receive decode
  wire [3:0] rxNeed = serial_port_pkg::DATA_BITS + {3'h0, wakeOn} + {3'h0, parOn} + 4'h1;
  wire serial_port_pkg::rx_char_t rxChar = serial_port_pkg::decode_frame(rxBits_q, wakeOn,
      parOn, parOdd);
  wire rxGo = rxDone_q & rxEnable;
  // unaddressed stations take only ninth-bit characters
  wire rxAccept = rxGo & (~wakeOn | rxChar.wake | rxAwake_q);
  wire rxCrcByte = rxAccept & (rxCrcLeft_q != 2'h0);
  wire rxDataByte = rxAccept & (rxCrcLeft_q == 2'h0);
  wire rxEmpty = rxCount_q == 3'h0;
  wire rxHold = peFlag_q | bfFlag_q | (rxCount_q == serial_port_pkg::FIFO_DEPTH);
  wire rxPush = rxDataByte & ~rxHold;
  wire rxOverrun = rxDataByte & rxHold; // byte is lost
  wire rxBlockEnd = rxPush & (rxIdx_q == blockLast);
  wire rxFullNow = rxPush & (rxCount_q == serial_port_pkg::FIFO_DEPTH - 3'h1);
  wire [15:0] rxCrcNext = serial_port_pkg::crc_step((rxDataByte & (rxIdx_q == 6'h00)) ?
      serial_port_pkg::CRC_INIT : rxCrc_q, rxChar.data);
  wire rxCrcBad = rxCrcByte & (rxCrcLeft_q == 2'h1) & (rxCrcNext != 16'h0000);
  // host may read only after packet end or buffer full
  wire rxPop = rdEn & hitData & (peFlag_q | bfFlag_q) & ~rxEmpty;
  wire rxDrained = rxPop & (rxCount_q == 3'h1);

  // status and interrupt
  logic [7:0] statusByte;
  always_comb begin
    statusByte = 8'h00;
    statusByte[serial_port_pkg::S_PE] = peFlag_q;
    statusByte[serial_port_pkg::S_BF] = bfFlag_q;
    statusByte[serial_port_pkg::S_TXE] = txEmpty;
    statusByte[serial_port_pkg::S_FE] = feFlag_q;
    statusByte[serial_port_pkg::S_OVR] = ovrFlag_q;
    statusByte[serial_port_pkg::S_PAR] = parFlag_q;
    statusByte[serial_port_pkg::S_CRC] = crcFlag_q;
    statusByte[serial_port_pkg::S_TXBUSY] = txRelease_q | ~txIdle;
  end
  wire intCause = peFlag_q | bfFlag_q | txEmpty;
  wire intLevel = cmd6_q[serial_port_pkg::C6_INT_HIGH] ? intCause : ~intCause;

  // read mux: unselected offsets answer zero, the bus side never floats
  wire [7:0] rdMux =
      hitData ? (rxPop ? rxMem[rxRd_q] : 8'h00) :
      hitCmd1 ? statusByte :
      hitCmd2 ? cmd2_q :
      hitCmd3 ? cmd3_q :
      hitCmd4 ? cmd4_q :
      hitCmd5 ? cmd5_q :
      hitCmd6 ? cmd6_q : 8'h00;

  // outputs
  assign ack_o = ack_q;
  assign dat_o = {24'h000000, rdData_q};
  assign serialOut = serialOut_q;
  assign rtsOut = cmd4_q[serial_port_pkg::C4_RTS];
  assign portOutZero = cmd6_q[serial_port_pkg::C6_P0];
  assign portOutOnePacketDone = cmd6_q[serial_port_pkg::C6_P1_MODE] ? txDone_q :
      cmd6_q[serial_port_pkg::C6_P1_LEVEL];
  assign intOut = intOut_q;

  // bus answer one cycle after the request, dropped the cycle after
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      rdData_q <= 8'h00;
    end else begin
      ack_q <= busReq;
      if (rdEn) begin
        rdData_q <= rdMux;
      end
    end
  end

  // command writes; reset returns every setting to zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd1_q <= serial_port_pkg::CMD_RESET;
      cmd2_q <= serial_port_pkg::CMD_RESET;
      cmd3_q <= serial_port_pkg::CMD_RESET;
      cmd4_q <= serial_port_pkg::CMD_RESET;
      cmd5_q <= serial_port_pkg::CMD_RESET;
      cmd6_q <= serial_port_pkg::CMD_RESET;
    end else if (wrEn) begin
      if (hitCmd1) cmd1_q <= dat_i[7:0];
      if (hitCmd2) cmd2_q <= dat_i[7:0];
      if (hitCmd3) cmd3_q <= dat_i[7:0];
      if (hitCmd4) cmd4_q <= dat_i[7:0];
      if (hitCmd5) cmd5_q <= dat_i[7:0];
      if (hitCmd6) cmd6_q <= dat_i[7:0];
    end
  end

  // pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rxSync_q <= 3'h7;
      ctsSync_q <= 3'h7;
      rxLine_q <= 1'b1;
      ctsLine_q <= 1'b1;
    end else begin
      rxSync_q <= {rxSync_q[1:0], serialIn};
      ctsSync_q <= {ctsSync_q[1:0], ctsN};
      if (rxSync_q[1] == rxSync_q[2]) rxLine_q <= rxSync_q[2];
      if (ctsSync_q[1] == ctsSync_q[2]) ctsLine_q <= ctsSync_q[2];
    end
  end

  // rate generator
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      preCnt_q <= 5'h00;
      divCnt_q <= 8'h00;
    end else begin
      preCnt_q <= preTick ? 5'h00 : preCnt_q + 5'h01;
      if (preTick) divCnt_q <= (divCnt_q == cmd2_q) ? 8'h00 : divCnt_q + 8'h01;
    end
  end

  // transmit fifo; a group is released only when complete
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      txWr_q <= 2'h0;
      txRd_q <= 2'h0;
      txCount_q <= 3'h0;
      txWrIdx_q <= 6'h00;
      txGroupDone_q <= 1'b0;
      txRelease_q <= 1'b0;
    end else begin
      if (txPush) begin
        txMem[txWr_q] <= dat_i[7:0];
        txWr_q <= txWr_q + 2'h1;
        txWrIdx_q <= txBlockEndW ? 6'h00 : txWrIdx_q + 6'h01;
        // end of any block or four bytes of a long one
        txGroupDone_q <= txBlockEndW | (txCount_q == serial_port_pkg::FIFO_DEPTH - 3'h1);
      end else if (txGo) begin
        txGroupDone_q <= 1'b0;
        txRelease_q <= 1'b1;
      end
      if (txPop) begin
        txRd_q <= txRd_q + 2'h1;
        if (txCount_q == 3'h1) txRelease_q <= 1'b0;
      end
      txCount_q <= txCount_q + {2'h0, txPush} - {2'h0, txPop};
    end
  end

  // transmit block bookkeeping: position, check bytes, completion
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      txIdx_q <= 6'h00;
      txCrc_q <= serial_port_pkg::CRC_INIT;
      txCrcLeft_q <= 2'h0;
      txLast_q <= 1'b0;
      txDone_q <= 1'b0;
    end else begin
      if (txStartData) begin
        txIdx_q <= txBlockEndS ? 6'h00 : txIdx_q + 6'h01;
        txCrc_q <= txCrcNext;
        if (txBlockEndS & crcOn) txCrcLeft_q <= serial_port_pkg::CRC_BYTES;
        txLast_q <= txBlockEndS & ~crcOn;
        if (txFirst) txDone_q <= 1'b0;
      end else if (txStartCrc) begin
        txCrcLeft_q <= txCrcLeft_q - 2'h1;
        txLast_q <= txCrcLeft_q == 2'h1;
      end
      if (txBitEnd & (txLeft_q == 4'h1) & txLast_q) txDone_q <= 1'b1;
    end
  end

  // transmit shifter, one bit per sixteen rate pulses
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      txState_q <= serial_port_pkg::TX_IDLE;
      txFrame_q <= 12'hfff;
      txLeft_q <= 4'h0;
      txPhase_q <= 4'h0;
      serialOut_q <= 1'b1; // mark after reset
    end else begin
      unique case (txState_q)
        serial_port_pkg::TX_IDLE: begin
          serialOut_q <= 1'b1; // mark between characters
          if (txStartData | txStartCrc) begin
            txFrame_q <= txNew.bits;
            txLeft_q <= txNew.len;
            txPhase_q <= 4'h0;
            serialOut_q <= txNew.bits[0];
            txState_q <= serial_port_pkg::TX_SEND;
          end
        end
        serial_port_pkg::TX_SEND: begin
          if (tick16) txPhase_q <= txPhase_q + 4'h1;
          if (txBitEnd) begin
            if (txLeft_q == 4'h1) begin
              serialOut_q <= 1'b1;
              txState_q <= serial_port_pkg::TX_IDLE;
            end else begin
              txFrame_q <= {1'b1, txFrame_q[11:1]};
              serialOut_q <= txFrame_q[1];
              txLeft_q <= txLeft_q - 4'h1;
            end
          end
        end
      endcase
    end
  end

  // receive sampler: start checked at mid bit, then every bit centre
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rxState_q <= serial_port_pkg::RX_IDLE;
      rxPhase_q <= 4'h0;
      rxPos_q <= 4'h0;
      rxBits_q <= 11'h000;
      rxDone_q <= 1'b0;
    end else begin
      rxDone_q <= 1'b0;
      unique case (rxState_q)
        serial_port_pkg::RX_IDLE: begin
          rxPhase_q <= 4'h0;
          if (rxEnable & ~rxLine_q) rxState_q <= serial_port_pkg::RX_START;
        end
        serial_port_pkg::RX_START: begin
          if (tick16) begin
            rxPhase_q <= rxPhase_q + 4'h1;
            if (rxPhase_q == serial_port_pkg::TICK_MID) begin
              rxPhase_q <= 4'h0;
              rxPos_q <= 4'h0;
              rxState_q <= rxLine_q ? serial_port_pkg::RX_IDLE :
                  serial_port_pkg::RX_BITS; // glitch rejected
            end
          end
        end
        serial_port_pkg::RX_BITS: begin
          if (tick16) begin
            rxPhase_q <= rxPhase_q + 4'h1;
            if (rxPhase_q == serial_port_pkg::TICK_LAST) begin
              rxBits_q[rxPos_q] <= rxLine_q; // centre sample
              rxPos_q <= rxPos_q + 4'h1;
              if (rxPos_q == rxNeed - 4'h1) begin
                rxDone_q <= 1'b1;
                rxState_q <= serial_port_pkg::RX_IDLE;
              end
            end
          end
        end
        default: rxState_q <= serial_port_pkg::RX_IDLE;
      endcase
    end
  end

  // receive fifo and block position
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rxWr_q <= 2'h0;
      rxRd_q <= 2'h0;
      rxCount_q <= 3'h0;
      rxIdx_q <= 6'h00;
      rxCrc_q <= serial_port_pkg::CRC_INIT;
      rxCrcLeft_q <= 2'h0;
      rxAwake_q <= 1'b0;
    end else begin
      if (rxPush) begin
        rxMem[rxWr_q] <= rxChar.data; // bad bytes stored too
        rxWr_q <= rxWr_q + 2'h1;
        rxIdx_q <= rxBlockEnd ? 6'h00 : rxIdx_q + 6'h01;
        if (rxBlockEnd & crcOn) rxCrcLeft_q <= serial_port_pkg::CRC_BYTES;
      end
      if (rxPush | rxCrcByte) rxCrc_q <= rxCrcNext;
      if (rxCrcByte) rxCrcLeft_q <= rxCrcLeft_q - 2'h1;
      if (rxGo & wakeOn & rxChar.wake) rxAwake_q <= rxChar.data == cmd5_q;
      if (rxPop) rxRd_q <= rxRd_q + 2'h1;
      rxCount_q <= rxCount_q + {2'h0, rxPush} - {2'h0, rxPop};
    end
  end

  // sticky flags: a setting event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      peFlag_q <= 1'b0;
      bfFlag_q <= 1'b0;
      feFlag_q <= 1'b0;
      ovrFlag_q <= 1'b0;
      parFlag_q <= 1'b0;
      crcFlag_q <= 1'b0;
      intOut_q <= 1'b1;
    end else begin
      peFlag_q <= (peFlag_q & ~rxDrained) | rxBlockEnd;
      bfFlag_q <= (bfFlag_q & ~rxDrained) | rxFullNow;
      feFlag_q <= (feFlag_q & ~faultClear) | (rxPush & rxChar.frameErr);
      ovrFlag_q <= (ovrFlag_q & ~faultClear) | rxOverrun;
      parFlag_q <= (parFlag_q & ~faultClear) | (rxPush & rxChar.parErr);
      crcFlag_q <= (crcFlag_q & ~faultClear) | rxCrcBad;
      intOut_q <= intLevel;
    end
  end

endmodule // block_fifo_async_serial_port

`default_nettype wire

// >>> dv/serial_port_props.sv
// Purpose: bus and pin relations of the block serial port
// Assumes: one clock domain, asynchronous low reset
// Notes: only the ports these relations need are watched
`timescale 1ns/1ps
`default_nettype none
module serial_port_props (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic rtsOut,
  input wire logic portOutZero,
  input wire logic portOutOnePacketDone
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire logic take = cyc_i & stb_i & !ack_o; // request taken at this edge
  wire logic cw = take & we_i & sel_i[0]; // low byte lane written
  AST_ACK_NEXT: assert property (take |=> ack_o)
    else $error("no ack after request");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i & stb_i))
    else $error("ack without request");
  AST_HIGH_ZERO: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_UNMAPPED: assert property (take & !we_i & adr_i > 8'h18 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RTS: assert property (cw & adr_i == 8'h10 |=> rtsOut == $past(dat_i[3]))
    else $error("rts not following command");
  AST_PORT0: assert property (cw & adr_i == 8'h18 |=> portOutZero == $past(dat_i[0]))
    else $error("port zero not following command");
  AST_PORT1: assert property (cw & adr_i == 8'h18 & !dat_i[1]
    |=> portOutOnePacketDone == $past(dat_i[3]))
    else $error("port one level wrong");
  // main scenarios seen at least once
  cover property (cw & adr_i == 8'h10);
  cover property (take & !we_i & adr_i == 8'h00);
  cover property (take & we_i & adr_i == 8'h00);
endmodule // serial_port_props
bind block_fifo_async_serial_port serial_port_props u_serial_port_props (.clock, .arst_n,
  .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rtsOut, .portOutZero,
  .portOutOnePacketDone);
`default_nettype wire

// >>> dv/remote_station.sv
// Purpose: far station that hands every character straight back
// Assumes: same clock as the port, line idles at mark
// Notes: a plain wire with one flop of line delay
`timescale 1ns/1ps
`default_nettype none
module remote_station (
  input wire logic clock,
  input wire logic txLine, // what the port sends
  output logic rxLine // what the port hears
);
  // loop the line back, so frames return unchanged
  always @(posedge clock) begin
    rxLine <= txLine;
  end
endmodule // remote_station
`default_nettype wire

// >>> dv/testbench.sv
// Purpose: self-checking bench for the block serial port
// Assumes: looped-back far end, bit time of 32 clocks
// Notes: byte enables are held constant; clear-to-send gates one block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 0, arst_n = 0, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, serialIn, serialOut;
  logic ctsN = 0, rtsOut, intOut, portOutZero, portOutOnePacketDone;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  int errors = 0, checkCount = 0, cycles = 0;
  always #20 clock = ~clock; // 25 MHz
  block_fifo_async_serial_port u_block_fifo_async_serial_port (.clock, .arst_n, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .serialIn, .serialOut, .ctsN,
    .rtsOut, .intOut, .portOutZero, .portOutOnePacketDone);
  remote_station u_remote_station (.clock, .txLine(serialOut), .rxLine(serialIn));
  // one classic cycle, held until ack is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, d};
    do begin
      @(posedge clock);
    end while (ack_o !== 1'b1); // only the bench timeout ends a wait
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clock);
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic printVerdict();
    $display("checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, far above the expected run
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      printVerdict();
    end
  end
  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, 8'h04, 8'h0);
    check("status", q, 32'h4);
    bus(1'b0, 8'h10, 8'h0);
    check("cmd4", q, 32'h0);
    bus(1'b0, 8'h1c, 8'h0);
    check("unmapped", q, 32'h0);
    bus(1'b0, 8'h00, 8'h0);
    check("early read", q, 32'h0);
    bus(1'b1, 8'h0c, 8'h01);
    bus(1'b1, 8'h10, 8'h0b);
    bus(1'b1, 8'h18, 8'h01);
    check("rts", rtsOut, 32'h1);
    check("port0", portOutZero, 32'h1);
    check("port1", portOutOnePacketDone, 32'h0);
    bus(1'b1, 8'h00, 8'ha5);
    bus(1'b1, 8'h00, 8'h3c);
    for (int i = 0; i < 400 && q[0] !== 1'b1; i++) bus(1'b0, 8'h04, 8'h0);
    check("packet end", q[6:0], 32'h5);
    check("int low", intOut, 32'h0);
    bus(1'b0, 8'h00, 8'h0);
    check("byte 1", q, 32'ha5);
    bus(1'b0, 8'h00, 8'h0);
    check("byte 2", q, 32'h3c);
    bus(1'b0, 8'h04, 8'h0);
    check("drained", q, 32'h4);
    bus(1'b1, 8'h18, 8'h06);
    check("int high", intOut, 32'h1);
    check("tx done", portOutOnePacketDone, 32'h1);
    // wake and parity block held back by clear-to-send, then released
    ctsN <= 1'b1;
    bus(1'b1, 8'h04, 8'h02);
    bus(1'b1, 8'h14, 8'h5a);
    bus(1'b1, 8'h10, 8'h0f);
    bus(1'b1, 8'h00, 8'h5a);
    bus(1'b1, 8'h00, 8'h81);
    repeat (40) @(posedge clock);
    bus(1'b0, 8'h04, 8'h0);
    check("cts held", q, 32'h0);
    check("int idle", intOut, 32'h0);
    ctsN <= 1'b0;
    for (int i = 0; i < 400 && q[0] !== 1'b1; i++) bus(1'b0, 8'h04, 8'h0);
    check("wake block", q[6:0], 32'h5);
    // a second block while packet end holds the fifo is lost
    bus(1'b1, 8'h00, 8'h5a);
    bus(1'b1, 8'h00, 8'h81);
    for (int i = 0; i < 400 && q !== 32'h15; i++) bus(1'b0, 8'h04, 8'h0);
    check("overrun", q, 32'h15);
    bus(1'b0, 8'h00, 8'h0);
    check("wake byte 1", q, 32'h5a);
    bus(1'b0, 8'h00, 8'h0);
    check("wake byte 2", q, 32'h81);
    bus(1'b1, 8'h10, 8'h1f);
    bus(1'b0, 8'h04, 8'h0);
    check("fault clear", q, 32'h4);
    // second reset in mid-run returns the commands to zero
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    check("rts after reset", rtsOut, 32'h0);
    bus(1'b0, 8'h14, 8'h0);
    check("cmd5 after reset", q, 32'h0);
    printVerdict();
  end
endmodule // testbench
`default_nettype wire
